/* nvm_access.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nvm_cfg.svh"

module nvm_access #(
	parameter int unsigned OP_CYCLES = `NVM_PROG_TIME_NS / `NVM_CLK_PERIOD_NS
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_awaddr,
	input  wire logic [2:0]  s_awprot,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	output logic [1:0]       s_bresp,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	input  wire logic [31:0] s_araddr,
	input  wire logic [2:0]  s_arprot,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output nvm_pkg::nvm_cmd_t   mem_cmd,
	output nvm_pkg::nvm_space_t mem_space,
	output logic [14:0]      mem_addr,
	output logic [13:0]      mem_wdata,
	input  wire logic [13:0] mem_rdata,
	output logic             cpu_stall
);
	nvm_op_if op ();

	nvm_op_timer #(
		.OP_CYCLES (OP_CYCLES)
	) u_timer (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.op      (op)
	);

	// register contents
	logic [7:0]           data_low;
	logic [5:0]           data_high;
	logic [7:0]           addr_low;
	logic [6:0]           addr_high;
	logic                 flash_space_sel;
	logic                 config_space_sel;
	logic                 latch_only;
	logic                 erase_sel;
	logic                 sequence_fault;
	logic                 program_allow;
	logic                 write_start;
	logic                 read_start;
	logic                 unlock_half;
	logic                 unlock_armed;
	logic                 op_erase;
	nvm_pkg::nvm_state_t  state;
	logic [7:0]           aw_addr;
	logic [7:0]           w_byte;
	logic                 w_lane0;

	// bus write strobes
	logic       wr_fire;
	logic       ctl_wr;
	logic       unlock_wr;
	logic       wr_try;
	logic       rd_try;
	logic       new_cfg;
	logic       new_flash;
	logic       start_ok;
	logic       start_timed;
	logic       finish;
	logic [15:0] cfg_full;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `NVM_OFF_DATA_LOW) || (a == `NVM_OFF_DATA_HIGH) ||
			(a == `NVM_OFF_ADDR_LOW) || (a == `NVM_OFF_ADDR_HIGH) ||
			(a == `NVM_OFF_CONTROL) || (a == `NVM_OFF_UNLOCK);
	endfunction

	// config words and device id may be read but never written
	function automatic logic cfg_readable(input logic [15:0] a);
		cfg_readable = (a >= `NVM_CFG_UID_FIRST && a <= `NVM_CFG_UID_LAST) ||
			(a == `NVM_CFG_DEV_ID) ||
			(a >= `NVM_CFG_WORD_FIRST && a <= `NVM_CFG_WORD_LAST);
	endfunction

	function automatic logic cfg_writable(input logic [15:0] a);
		cfg_writable = (a >= `NVM_CFG_UID_FIRST) && (a <= `NVM_CFG_UID_LAST);
	endfunction

	// write happens once both address and data are held and no response is pending
	assign wr_fire   = !s_awready && !s_wready && !s_bvalid;
	assign ctl_wr    = wr_fire && w_lane0 && (aw_addr == `NVM_OFF_CONTROL);
	assign unlock_wr = wr_fire && w_lane0 && (aw_addr == `NVM_OFF_UNLOCK);
	assign wr_try    = ctl_wr && w_byte[`NVM_BIT_WRITE];
	assign rd_try    = ctl_wr && w_byte[`NVM_BIT_READ] && (state == nvm_pkg::ST_IDLE);
	assign new_cfg   = w_byte[`NVM_BIT_CFG_SEL];
	assign new_flash = w_byte[`NVM_BIT_FLASH_SEL];
	assign cfg_full  = {1'b1, addr_high, addr_low};

	// a start needs a fresh unlock, program-allow, an idle engine and a legal target
	assign start_ok = wr_try && (state == nvm_pkg::ST_IDLE) && unlock_armed &&
		w_byte[`NVM_BIT_ALLOW] && (!new_cfg || cfg_writable(cfg_full));
	// only latch-only loads on flash or config space skip the timer
	assign start_timed = start_ok && !(w_byte[`NVM_BIT_LATCH] && (new_cfg || new_flash) &&
		!w_byte[`NVM_BIT_ERASE]);
	assign op.start = start_timed;
	assign finish   = ((state == nvm_pkg::ST_BUSY) && op.done) || (state == nvm_pkg::ST_LATCH);

	// write address channel
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_awready <= 1'b1;
			aw_addr   <= 8'h00;
		end else if (s_awvalid && s_awready) begin
			s_awready <= 1'b0;
			aw_addr   <= s_awaddr[7:0];
		end else if (s_bvalid && s_bready) begin
			s_awready <= 1'b1;
		end
	end

	// write data channel; registers are one byte wide so only lane 0 counts
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_wready <= 1'b1;
			w_byte   <= 8'h00;
			w_lane0  <= 1'b0;
		end else if (s_wvalid && s_wready) begin
			s_wready <= 1'b0;
			w_byte   <= s_wdata[7:0];
			w_lane0  <= s_wstrb[0];
		end else if (s_bvalid && s_bready) begin
			s_wready <= 1'b1;
		end
	end

	// write response, raised on the same edge at which the write takes effect
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_bvalid <= 1'b0;
			s_bresp  <= `NVM_RESP_OKAY;
		end else if (wr_fire) begin
			s_bvalid <= 1'b1;
			s_bresp  <= is_mapped(aw_addr) ? `NVM_RESP_OKAY : `NVM_RESP_SLVERR;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// read channel; reads have no side effects
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= `NVM_RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rresp   <= is_mapped(s_araddr[7:0]) ? `NVM_RESP_OKAY : `NVM_RESP_SLVERR;
			unique case (s_araddr[7:0])
				`NVM_OFF_DATA_LOW:  s_rdata <= {24'h000000, data_low};
				`NVM_OFF_DATA_HIGH: s_rdata <= {24'h000000, 2'h0, data_high};
				`NVM_OFF_ADDR_LOW:  s_rdata <= {24'h000000, addr_low};
				`NVM_OFF_ADDR_HIGH: s_rdata <= {24'h000000, 1'b1, addr_high};
				`NVM_OFF_CONTROL:   s_rdata <= {24'h000000, flash_space_sel, config_space_sel,
					latch_only, erase_sel, sequence_fault, program_allow, write_start, read_start};
				default:            s_rdata <= 32'h0000_0000; // unlock register reads zero
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// address registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_low  <= 8'h00;
			addr_high <= 7'h00;
		end else if (wr_fire && w_lane0) begin
			if (aw_addr == `NVM_OFF_ADDR_LOW) begin
				addr_low <= w_byte;
			end
			if (aw_addr == `NVM_OFF_ADDR_HIGH) begin
				addr_high <= w_byte[6:0];
			end
		end
	end

	// data registers; a completed fetch wins over a bus write in the same cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_low  <= 8'h00;
			data_high <= 6'h00;
		end else if (state == nvm_pkg::ST_READ) begin
			if (config_space_sel && !cfg_readable(cfg_full)) begin
				data_low  <= 8'h00;
				data_high <= 6'h00;
			end else begin
				data_low  <= mem_rdata[7:0];
				data_high <= mem_rdata[13:8];
			end
		end else if (wr_fire && w_lane0) begin
			if (aw_addr == `NVM_OFF_DATA_LOW) begin
				data_low <= w_byte;
			end
			if (aw_addr == `NVM_OFF_DATA_HIGH) begin
				data_high <= w_byte[5:0];
			end
		end
	end

	// unlock tracker: 55h then AAh arms one start; any control write spends it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			unlock_half  <= 1'b0;
			unlock_armed <= 1'b0;
		end else if (unlock_wr) begin
			unlock_half  <= (w_byte == `NVM_UNLOCK_FIRST);
			unlock_armed <= unlock_half && (w_byte == `NVM_UNLOCK_SECOND);
		end else if (ctl_wr) begin
			unlock_half  <= 1'b0;
			unlock_armed <= 1'b0;
		end
	end

	// plain control bits; selects are frozen while an operation runs
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_space_sel  <= 1'b0;
			config_space_sel <= 1'b0;
			latch_only       <= 1'b0;
			program_allow    <= 1'b0;
		end else if (ctl_wr && (state == nvm_pkg::ST_IDLE)) begin
			flash_space_sel  <= w_byte[`NVM_BIT_FLASH_SEL];
			config_space_sel <= w_byte[`NVM_BIT_CFG_SEL];
			latch_only       <= w_byte[`NVM_BIT_LATCH];
			program_allow    <= w_byte[`NVM_BIT_ALLOW];
		end else if (ctl_wr) begin
			program_allow    <= w_byte[`NVM_BIT_ALLOW];
		end
	end

	// erase select is cleared by hardware when a row erase completes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			erase_sel <= 1'b0;
		end else if (finish && op_erase) begin
			erase_sel <= 1'b0;
		end else if (ctl_wr && (state == nvm_pkg::ST_IDLE)) begin
			erase_sel <= w_byte[`NVM_BIT_ERASE];
		end
	end

	// fault flag: any set attempt of write start raises it; the set beats every clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sequence_fault <= 1'b0;
		end else if (wr_try) begin
			sequence_fault <= 1'b1;
		end else if (finish) begin
			sequence_fault <= 1'b0; // normal completion
		end else if (ctl_wr) begin
			sequence_fault <= w_byte[`NVM_BIT_FAULT];
		end
	end

	// write start and read start are set-only from software, cleared by hardware
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			write_start <= 1'b0;
			read_start  <= 1'b0;
		end else begin
			if (start_ok) begin
				write_start <= 1'b1;
			end else if (finish) begin
				write_start <= 1'b0;
			end
			if (rd_try) begin
				read_start <= 1'b1;
			end else if (state == nvm_pkg::ST_READ) begin
				read_start <= 1'b0;
			end
		end
	end

	// engine: reads take one cycle, latch loads one cycle, the rest run on the timer
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= nvm_pkg::ST_IDLE;
			op_erase <= 1'b0;
		end else begin
			unique case (state)
				nvm_pkg::ST_IDLE: begin
					if (start_timed) begin
						state    <= nvm_pkg::ST_BUSY;
						op_erase <= (new_cfg || new_flash) && w_byte[`NVM_BIT_ERASE];
					end else if (start_ok) begin
						state    <= nvm_pkg::ST_LATCH;
						op_erase <= 1'b0;
					end else if (rd_try) begin
						state <= nvm_pkg::ST_READ;
					end
				end
				nvm_pkg::ST_READ:  state <= nvm_pkg::ST_IDLE;
				nvm_pkg::ST_LATCH: state <= nvm_pkg::ST_IDLE;
				nvm_pkg::ST_BUSY: begin
					if (op.done) begin
						state <= nvm_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// array command, shown for exactly one cycle with address, space and data
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_cmd   <= nvm_pkg::CMD_NONE;
			mem_space <= nvm_pkg::SPACE_EEPROM;
			mem_addr  <= 15'h0000;
			mem_wdata <= 14'h0000;
		end else if (start_ok || rd_try) begin
			mem_addr  <= {addr_high, addr_low};
			mem_wdata <= {data_high, data_low};
			mem_space <= new_cfg ? nvm_pkg::SPACE_CONFIG :
				(new_flash ? nvm_pkg::SPACE_FLASH : nvm_pkg::SPACE_EEPROM);
			if (!start_ok) begin
				mem_cmd <= nvm_pkg::CMD_READ;
			end else if (!new_cfg && !new_flash) begin
				mem_cmd <= nvm_pkg::CMD_EE_WRITE;
			end else if (w_byte[`NVM_BIT_ERASE]) begin
				mem_cmd <= nvm_pkg::CMD_ROW_ERASE;
			end else if (w_byte[`NVM_BIT_LATCH]) begin
				mem_cmd <= nvm_pkg::CMD_LATCH;
			end else begin
				mem_cmd <= nvm_pkg::CMD_LATCH_PROG;
			end
		end else begin
			mem_cmd <= nvm_pkg::CMD_NONE;
		end
	end

	// processor stall covers flash and config program/erase only; eeprom writes run behind it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cpu_stall <= 1'b0;
		end else if (start_timed && (new_cfg || new_flash)) begin
			cpu_stall <= 1'b1;
		end else if (finish) begin
			cpu_stall <= 1'b0;
		end
	end
endmodule

`default_nettype wire

/* nvm_cfg.svh */
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

// register byte offsets on the bus
`define NVM_OFF_DATA_LOW  8'h00
`define NVM_OFF_DATA_HIGH 8'h04
`define NVM_OFF_ADDR_LOW  8'h08
`define NVM_OFF_ADDR_HIGH 8'h0C
`define NVM_OFF_CONTROL   8'h10
`define NVM_OFF_UNLOCK    8'h14

// control register field positions
`define NVM_BIT_FLASH_SEL 7
`define NVM_BIT_CFG_SEL   6
`define NVM_BIT_LATCH     5
`define NVM_BIT_ERASE     4
`define NVM_BIT_FAULT     3
`define NVM_BIT_ALLOW     2
`define NVM_BIT_WRITE     1
`define NVM_BIT_READ      0

// unlock pattern, sent in this order
`define NVM_UNLOCK_FIRST  8'h55
`define NVM_UNLOCK_SECOND 8'hAA

// configuration space map
`define NVM_CFG_UID_FIRST 16'h8000
`define NVM_CFG_UID_LAST  16'h8003
`define NVM_CFG_DEV_ID    16'h8006
`define NVM_CFG_WORD_FIRST 16'h8007
`define NVM_CFG_WORD_LAST 16'h8008

// self-timed operation length
`define NVM_PROG_TIME_NS  2000000
`define NVM_CLK_PERIOD_NS 10

// bus responses
`define NVM_RESP_OKAY   2'h0
`define NVM_RESP_SLVERR 2'h2

`endif

/* nvm_pkg.sv */
package nvm_pkg;
	// command shown to the arrays for one cycle
	typedef enum logic [2:0] {
		CMD_NONE       = 3'h0,
		CMD_READ       = 3'h1,
		CMD_LATCH      = 3'h2,
		CMD_LATCH_PROG = 3'h3,
		CMD_ROW_ERASE  = 3'h4,
		CMD_EE_WRITE   = 3'h5
	} nvm_cmd_t;

	typedef enum logic [1:0] {
		SPACE_EEPROM = 2'h0,
		SPACE_FLASH  = 2'h1,
		SPACE_CONFIG = 2'h2
	} nvm_space_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_READ  = 4'h2,
		ST_LATCH = 4'h4,
		ST_BUSY  = 4'h8
	} nvm_state_t;
endpackage

/* nvm_op_if.sv */
`timescale 1ns/10ps
`default_nettype none

// start/complete handshake between the controller and its operation timer
interface nvm_op_if;
	logic start;
	logic busy;
	logic done;
	modport ctrl (output start, input busy, input done);
	modport timer (input start, output busy, output done);
endinterface

`default_nettype wire

/* nvm_op_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module nvm_op_timer #(
	parameter int unsigned OP_CYCLES = 200000
) (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	nvm_op_if.timer   op
);
	localparam int unsigned CW = $clog2(OP_CYCLES + 1);

	logic [CW-1:0] remain;

	// done pulses OP_CYCLES edges after the start edge; a start while busy is dropped
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			remain  <= '0;
			op.busy <= 1'b0;
			op.done <= 1'b0;
		end else begin
			op.done <= 1'b0;
			if (op.start && !op.busy) begin
				remain  <= CW'(OP_CYCLES - 1);
				op.busy <= 1'b1;
			end else if (op.busy) begin
				if (remain == '0) begin
					op.busy <= 1'b0;
					op.done <= 1'b1;
				end else begin
					remain <= remain - 1'b1;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* nvm_access_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module nvm_access_checker #(
	parameter int unsigned OP_CYCLES = 8
) (
	input wire logic                ref_clk,
	input wire logic                rst_b,
	input wire logic                s_arvalid,
	input wire logic                s_arready,
	input wire logic [31:0]         s_araddr,
	input wire logic                s_rvalid,
	input wire logic [31:0]         s_rdata,
	input wire nvm_pkg::nvm_cmd_t   mem_cmd,
	input wire nvm_pkg::nvm_space_t mem_space,
	input wire logic                cpu_stall
);
	logic [7:0]  rd_off;
	logic [31:0] stall_cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// remember which register the pending read targets
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			rd_off <= 8'h00;
		else if (s_arvalid && s_arready)
			rd_off <= s_araddr[7:0];
	end
	// length of the current stall; zero while the core runs
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			stall_cnt <= 32'h0;
		else if (cpu_stall)
			stall_cnt <= stall_cnt + 32'h1;
		else
			stall_cnt <= 32'h0;
	end
	a_cmd_pulse: assert property (mem_cmd != nvm_pkg::CMD_NONE |=> mem_cmd == nvm_pkg::CMD_NONE)
		else $error("array command held longer than one cycle");
	// the stall spans the timer count plus the cycle in which the engine sees done
	a_stall_len: assert property ($fell(cpu_stall) |-> stall_cnt == OP_CYCLES + 1)
		else $error("stall length differs from the operation time");
	a_stall_cause: assert property ($rose(cpu_stall) |-> mem_cmd inside {nvm_pkg::CMD_LATCH_PROG,
		nvm_pkg::CMD_ROW_ERASE} && mem_space != nvm_pkg::SPACE_EEPROM)
		else $error("stall without a program or erase");
	a_latch_free: assert property (mem_cmd == nvm_pkg::CMD_LATCH |-> !cpu_stall)
		else $error("latch load stalled the core");
	a_prog_stall: assert property (mem_cmd inside {nvm_pkg::CMD_LATCH_PROG, nvm_pkg::CMD_ROW_ERASE}
		|-> cpu_stall ##1 cpu_stall)
		else $error("program or erase without stall");
	a_ee_space: assert property (mem_cmd == nvm_pkg::CMD_EE_WRITE |-> mem_space == nvm_pkg::SPACE_EEPROM
		##1 !cpu_stall)
		else $error("eeprom write misdirected or stalled");
	a_addr_high: assert property (s_rvalid && rd_off == 8'h0C |-> s_rdata[31:7] == 25'h1)
		else $error("address high top bits wrong");
	a_data_high: assert property (s_rvalid && rd_off == 8'h04 |-> s_rdata[31:6] == 26'h0)
		else $error("data high top bits not zero");
	a_rd_unmapped: assert property (s_rvalid && rd_off >= 8'h18 |-> s_rdata == 32'h0)
		else $error("unmapped read returned data");
	c_prog: cover property (mem_cmd == nvm_pkg::CMD_LATCH_PROG);
	c_erase: cover property (mem_cmd == nvm_pkg::CMD_ROW_ERASE);
	c_ee: cover property (mem_cmd == nvm_pkg::CMD_EE_WRITE);
endmodule
bind nvm_access nvm_access_checker #(.OP_CYCLES(OP_CYCLES)) chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr), .s_rvalid(s_rvalid),
	.s_rdata(s_rdata), .mem_cmd(mem_cmd), .mem_space(mem_space), .cpu_stall(cpu_stall));
`default_nettype wire

/* nvm_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nvm_mem_model (
	input  wire logic                ref_clk,
	input  wire nvm_pkg::nvm_cmd_t   mem_cmd,
	input  wire nvm_pkg::nvm_space_t mem_space,
	input  wire logic [14:0]         mem_addr,
	input  wire logic [13:0]         mem_wdata,
	output logic [13:0]              mem_rdata
);
	logic [13:0]         flash [0:255];
	logic [7:0]          ee [0:255];
	logic [13:0]         cfg [0:15];
	logic [13:0]         latch;
	logic [13:0]         spin;
	int                  n_cmd;
	nvm_pkg::nvm_cmd_t   last_cmd;
	nvm_pkg::nvm_space_t last_space;
	// contents derived from the index so the bench can predict them
	initial begin
		for (int i = 0; i < 256; i++) begin
			flash[i] = {6'h15, i[7:0]};
			ee[i] = i[7:0] ^ 8'hC3;
		end
		for (int i = 0; i < 16; i++) begin
			cfg[i] = {6'h10, i[7:0]};
		end
		spin = 14'h2AAA;
		latch = 14'h0;
		n_cmd = 0;
		last_cmd = nvm_pkg::CMD_NONE;
		last_space = nvm_pkg::SPACE_EEPROM;
	end
	// data only in the read-command cycle; otherwise a wandering value, so stale reads show
	always_comb begin
		if (mem_cmd != nvm_pkg::CMD_READ)
			mem_rdata = spin;
		else if (mem_space == nvm_pkg::SPACE_EEPROM)
			mem_rdata = {6'h00, ee[mem_addr[7:0]]};
		else if (mem_space == nvm_pkg::SPACE_FLASH)
			mem_rdata = flash[mem_addr[7:0]];
		else
			mem_rdata = cfg[mem_addr[3:0]];
	end
	// array side effects of each command; a row is 32 words here
	always @(posedge ref_clk) begin
		spin <= spin + 14'h1357;
		if (mem_cmd != nvm_pkg::CMD_NONE) begin
			n_cmd <= n_cmd + 1;
			last_cmd <= mem_cmd;
			last_space <= mem_space;
		end
		case (mem_cmd)
			nvm_pkg::CMD_LATCH: latch <= mem_wdata;
			nvm_pkg::CMD_LATCH_PROG: begin
				if (mem_space == nvm_pkg::SPACE_CONFIG)
					cfg[mem_addr[3:0]] <= mem_wdata;
				else
					flash[mem_addr[7:0]] <= mem_wdata;
			end
			nvm_pkg::CMD_ROW_ERASE: begin
				for (int i = 0; i < 256; i++)
					if (i[7:5] == mem_addr[7:5])
						flash[i] <= 14'h3FFF;
			end
			nvm_pkg::CMD_EE_WRITE: ee[mem_addr[7:0]] <= mem_wdata[7:0];
			default: ;
		endcase
	end
endmodule
`default_nettype wire

/* nvm_access_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module nvm_access_tb;
	logic                ref_clk, rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic [31:0]         s_awaddr, s_wdata, s_araddr, s_rdata, d;
	logic                s_awready, s_wready, s_bvalid, s_arready, s_rvalid, cpu_stall;
	logic [1:0]          s_bresp, s_rresp, r;
	nvm_pkg::nvm_cmd_t   mem_cmd;
	nvm_pkg::nvm_space_t mem_space;
	logic [14:0]         mem_addr;
	logic [13:0]         mem_wdata, mem_rdata;
	int                  fails, n_compared, cyc, n0;
	// short operation time keeps the run brief
	nvm_access #(.OP_CYCLES(16)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_awaddr(s_awaddr), .s_awprot(3'h0), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_wdata(s_wdata), .s_wstrb(4'hF), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr), .s_arprot(3'h0),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp), .mem_cmd(mem_cmd),
		.mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.cpu_stall(cpu_stall));
	nvm_mem_model mem (.ref_clk(ref_clk), .mem_cmd(mem_cmd), .mem_space(mem_space), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	task automatic give_verdict;
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
		bit got;
		got = 0;
		@(posedge ref_clk);
		s_awaddr <= {24'h0, a};
		s_wdata <= {24'h0, v};
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!got) begin
			@(posedge ref_clk);
			if (s_awvalid && s_awready)
				s_awvalid <= 1'b0;
			if (s_wvalid && s_wready)
				s_wvalid <= 1'b0;
			if (s_bvalid) begin
				chk("bresp", {30'h0, s_bresp}, {30'h0, er});
				s_bready <= 1'b0;
				got = 1;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
		bit got;
		got = 0;
		@(posedge ref_clk);
		s_araddr <= {24'h0, a};
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		while (!got) begin
			@(posedge ref_clk);
			if (s_arvalid && s_arready)
				s_arvalid <= 1'b0;
			if (s_rvalid) begin
				dv = s_rdata;
				rv = s_rresp;
				s_rready <= 1'b0;
				got = 1;
			end
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a, d, r);
		chk($sformatf("reg %h", a), d, e);
	endtask
	task automatic unl;
		wr(8'h14, 8'h55, 2'h0);
		wr(8'h14, 8'hAA, 2'h0);
	endtask
	// poll until the write-start bit falls, bounded
	task automatic idle;
		int k;
		k = 0;
		do begin
			rd(8'h10, d, r);
			k++;
		end while (d[1] !== 1'b0 && k < 40);
		chk("wr busy", {31'h0, d[1]}, 32'h0);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// hang guard: far above the few hundred cycles the tests need
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		{rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h0;
		{s_awaddr, s_wdata, s_araddr} = 96'h0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdc(8'h0C, 32'h80);
		rdc(8'h08, 32'h00);
		rdc(8'h10, 32'h00);
		wr(8'h04, 8'hFF, 2'h0);
		rdc(8'h04, 32'h3F);
		wr(8'h0C, 8'hFF, 2'h0);
		rdc(8'h0C, 32'hFF);
		wr(8'h00, 8'hA5, 2'h0);
		rdc(8'h00, 32'hA5);
		wr(8'h08, 8'h5A, 2'h0);
		rdc(8'h08, 32'h5A);
		wr(8'h18, 8'h77, 2'h2);
		rd(8'h18, d, r);
		chk("rresp", {30'h0, r}, 32'h2);
		chk("rdata", d, 32'h0);
		wr(8'h0C, 8'h00, 2'h0);
		wr(8'h08, 8'h12, 2'h0);
		wr(8'h10, 8'h01, 2'h0);
		rdc(8'h10, 32'h00);
		rdc(8'h00, 32'hD1);
		rdc(8'h04, 32'h00);
		wr(8'h10, 8'h81, 2'h0);
		rdc(8'h00, 32'h12);
		rdc(8'h04, 32'h15);
		wr(8'h08, 8'h06, 2'h0);
		wr(8'h10, 8'h41, 2'h0);
		rdc(8'h00, 32'h06);
		rdc(8'h04, 32'h10);
		wr(8'h08, 8'h05, 2'h0);
		wr(8'h10, 8'h41, 2'h0);
		rdc(8'h00, 32'h00);
		rdc(8'h04, 32'h00);
		wr(8'h08, 8'h20, 2'h0);
		wr(8'h00, 8'h3C, 2'h0);
		wr(8'h04, 8'h2A, 2'h0);
		n0 = mem.n_cmd;
		wr(8'h10, 8'h86, 2'h0);
		rdc(8'h10, 32'h8C);
		wr(8'h14, 8'hAA, 2'h0);
		wr(8'h14, 8'h55, 2'h0);
		wr(8'h10, 8'h86, 2'h0);
		rdc(8'h10, 32'h8C);
		unl();
		wr(8'h10, 8'h82, 2'h0);
		rdc(8'h10, 32'h88);
		chk("cmds", mem.n_cmd, n0);
		unl();
		wr(8'h10, 8'hA6, 2'h0);
		idle();
		chk("cmd", mem.last_cmd, nvm_pkg::CMD_LATCH);
		chk("latch", mem.latch, 32'h2A3C);
		chk("word", mem.flash[8'h20], 32'h1520);
		unl();
		wr(8'h10, 8'h86, 2'h0);
		wr(8'h10, 8'h04, 2'h0);
		rd(8'h10, d, r);
		chk("wr held", {31'h0, d[1]}, 32'h1);
		idle();
		rdc(8'h10, 32'h84);
		chk("word", mem.flash[8'h20], 32'h2A3C);
		wr(8'h10, 8'h81, 2'h0);
		rdc(8'h00, 32'h3C);
		rdc(8'h04, 32'h2A);
		unl();
		wr(8'h10, 8'h96, 2'h0);
		idle();
		rdc(8'h10, 32'h84);
		chk("erased", mem.flash[8'h20], 32'h3FFF);
		// the word read back before the erase still sits in the data pair: program it again
		unl();
		wr(8'h10, 8'h86, 2'h0);
		idle();
		chk("rewritten", mem.flash[8'h20], 32'h2A3C);
		wr(8'h08, 8'h40, 2'h0);
		wr(8'h00, 8'h99, 2'h0);
		unl();
		wr(8'h10, 8'h36, 2'h0);
		idle();
		chk("cmd", mem.last_cmd, nvm_pkg::CMD_EE_WRITE);
		chk("low ctl", {28'h0, d[3:0]}, 32'h4);
		wr(8'h10, 8'h01, 2'h0);
		rdc(8'h00, 32'h99);
		n0 = mem.n_cmd;
		wr(8'h08, 8'h07, 2'h0);
		unl();
		wr(8'h10, 8'h46, 2'h0);
		rdc(8'h10, 32'h4C);
		chk("cmds", mem.n_cmd, n0);
		wr(8'h08, 8'h01, 2'h0);
		unl();
		wr(8'h10, 8'h66, 2'h0);
		idle();
		chk("space", mem.last_space, nvm_pkg::SPACE_CONFIG);
		give_verdict();
	end
endmodule
`default_nettype wire
